// ===== src/rcr_regs.sv
// Control and configuration registers for regulator channels three and four
//
// Operation
// - Control bit 7 enables residual-voltage checking on the feedback input.
// - Control bit 5, reset one, connects output pull-down while channel off.
// - Control bit 4 gates overvoltage, undervoltage, short, limit comparators.
// - Control bit 3 picks setpoint register: zero first, one second.
// - Channel three bit 2 forces all phases and PWM; zero sheds phases.
// - Control bit 1, reset one, forces PWM; zero lets the mode vary.
// - Control bit 0 turns the regulator on; resets to zero.
// - Config bits 5:3 peak limit; 000/001 reserved, 2.5 to 7.5 A, reset 100.
// - Limit writes accepted while running; highest usable code may be capped.
// - Config bits 2:0 ramp rate, 33 down to 0.31 mV/us, reset 010.
// - Defaults come from nonvolatile memory; printed image is 0x22.
// - Offsets: ch3 control 0x8, ch3 config 0x9, ch4 control 0xA.
`timescale 1ns/10ps
`include "rcr_cfg.svh"

module rcr_regs (
   input  wire logic             clk_sys,
   input  wire logic             reset,
   // Register port from the serial control decoder
   input  wire rcr_pkg::rcr_addr_t reg_addr,
   input  wire logic             reg_wr_en,
   input  wire rcr_pkg::rcr_byte_t reg_wr_data,
   input  wire logic             reg_rd_en,
   output rcr_pkg::rcr_byte_t    reg_rd_data,
   output logic                  reg_rd_valid,
   // Defaults from nonvolatile memory
   input  wire logic             nvm_valid,
   input  wire rcr_pkg::rcr_byte_t nvm_ch3_control,
   input  wire rcr_pkg::rcr_byte_t nvm_ch3_config,
   input  wire rcr_pkg::rcr_byte_t nvm_ch4_control,
   // Cap on the peak current code from other device settings
   input  wire rcr_pkg::rcr_code_t peak_code_cap,
   // Setpoint registers held elsewhere
   input  wire rcr_pkg::rcr_byte_t ch3_setpoint_a,
   input  wire rcr_pkg::rcr_byte_t ch3_setpoint_b,
   input  wire rcr_pkg::rcr_byte_t ch4_setpoint_a,
   input  wire rcr_pkg::rcr_byte_t ch4_setpoint_b,
   // Channel three controls
   output logic                  ch3_residual_check_en,
   output logic                  ch3_pulldown_en,
   output logic                  ch3_monitor_en,
   output logic                  ch3_setpoint_select,
   output logic                  ch3_force_all_phases,
   output logic                  ch3_force_pwm,
   output logic                  ch3_regulator_on,
   output rcr_pkg::rcr_code_t    ch3_peak_current_code,
   output logic                  ch3_peak_code_valid,
   output rcr_pkg::rcr_code_t    ch3_ramp_code,
   output rcr_pkg::rcr_byte_t    ch3_setpoint_active,
   output logic                  ch3_pulldown_active,
   output logic                  ch3_overvoltage_cmp_en,
   output logic                  ch3_undervoltage_cmp_en,
   output logic                  ch3_short_circuit_cmp_en,
   output logic                  ch3_current_limit_cmp_en,
   output logic                  ch3_pulse_frequency_allowed,
   // Channel four controls
   output logic                  ch4_residual_check_en,
   output logic                  ch4_pulldown_en,
   output logic                  ch4_monitor_en,
   output logic                  ch4_setpoint_select,
   output logic                  ch4_force_pwm,
   output logic                  ch4_regulator_on,
   output rcr_pkg::rcr_byte_t    ch4_setpoint_active,
   output logic                  ch4_pulldown_active,
   output logic                  ch4_pulse_frequency_allowed
);
   import rcr_pkg::*;

   rcr_byte_t ch3_control_reg;
   rcr_byte_t ch3_control_next;
   rcr_byte_t ch3_config_reg;
   rcr_byte_t ch3_config_next;
   rcr_byte_t ch4_control_reg;
   rcr_byte_t ch4_control_next;
   rcr_byte_t rd_data_reg;
   rcr_byte_t rd_data_next;
   logic      rd_valid_reg;
   logic      rd_valid_next;
   rcr_byte_t img_ch3_control;
   rcr_byte_t img_ch3_config;
   rcr_byte_t img_ch4_control;
   rcr_code_t peak_raw;

   ////////////////////////////////////////////////////////////////////////////
   // Reset images: NVM content when valid, printed image otherwise
   always_comb begin
      if (nvm_valid) begin
         img_ch3_control = nvm_ch3_control & `RCR_CTRL_LIVE_MASK;
         img_ch3_config  = nvm_ch3_config & `RCR_CONF_LIVE_MASK;
         img_ch4_control = nvm_ch4_control & `RCR_CH4_LIVE_MASK;
      end else begin
         img_ch3_control = `RCR_RESET_IMAGE;
         img_ch3_config  = `RCR_RESET_IMAGE;
         img_ch4_control = `RCR_RESET_IMAGE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes; no guard on the running state so limits can move live
   always_comb begin
      ch3_control_next = ch3_control_reg;
      ch3_config_next  = ch3_config_reg;
      ch4_control_next = ch4_control_reg;
      if (reset) begin
         ch3_control_next = img_ch3_control;
         ch3_config_next  = img_ch3_config;
         ch4_control_next = img_ch4_control;
      end else if (reg_wr_en) begin
         if (reg_addr == `RCR_OFS_CH3_CONTROL) begin
            ch3_control_next = reg_wr_data;
         end else if (reg_addr == `RCR_OFS_CH3_CONFIG) begin
            ch3_config_next = reg_wr_data;
         end else if (reg_addr == `RCR_OFS_CH4_CONTROL) begin
            ch4_control_next = reg_wr_data;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      ch3_control_reg <= ch3_control_next;
      ch3_config_reg  <= ch3_config_next;
      ch4_control_reg <= ch4_control_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path, one cycle of latency; unmapped offsets read zero
   always_comb begin
      rd_valid_next = 1'b0;
      rd_data_next  = rd_data_reg;
      if (reset) begin
         rd_data_next = `RCR_UNMAPPED_DATA;
      end else if (reg_rd_en) begin
         rd_valid_next = 1'b1;
         if (reg_addr == `RCR_OFS_CH3_CONTROL) begin
            rd_data_next = ch3_control_reg;
         end else if (reg_addr == `RCR_OFS_CH3_CONFIG) begin
            rd_data_next = ch3_config_reg;
         end else if (reg_addr == `RCR_OFS_CH4_CONTROL) begin
            rd_data_next = ch4_control_reg;
         end else begin
            rd_data_next = `RCR_UNMAPPED_DATA;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
   end

   assign reg_rd_data  = rd_data_reg;
   assign reg_rd_valid = rd_valid_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Channel three field decode; reserved bit 6 drives nothing
   assign ch3_residual_check_en = ch3_control_reg[`RCR_BIT_RESIDUAL];
   assign ch3_pulldown_en       = ch3_control_reg[`RCR_BIT_PULLDOWN];
   assign ch3_monitor_en        = ch3_control_reg[`RCR_BIT_MONITOR];
   assign ch3_setpoint_select   = ch3_control_reg[`RCR_BIT_SETPOINT];
   assign ch3_force_all_phases  = ch3_control_reg[`RCR_BIT_ALL_PHASES];
   assign ch3_force_pwm         = ch3_control_reg[`RCR_BIT_FORCE_PWM];
   assign ch3_regulator_on      = ch3_control_reg[`RCR_BIT_REG_ON];

   // Pull-down only while the regulator is off
   assign ch3_pulldown_active = ch3_pulldown_en & ~ch3_regulator_on;

   // One gate for all four comparators
   assign ch3_overvoltage_cmp_en   = ch3_monitor_en;
   assign ch3_undervoltage_cmp_en  = ch3_monitor_en;
   assign ch3_short_circuit_cmp_en = ch3_monitor_en;
   assign ch3_current_limit_cmp_en = ch3_monitor_en;

   // Setpoint mux
   assign ch3_setpoint_active = ch3_setpoint_select ? ch3_setpoint_b
                                                    : ch3_setpoint_a;

   // All-phase implies forced PWM; either bit bars pulse-frequency mode
   assign ch3_pulse_frequency_allowed =
      ~(ch3_force_pwm | ch3_force_all_phases);

   // Peak limit: stored code is kept as written, applied code is capped
   assign peak_raw = ch3_config_reg[`RCR_PEAK_MSB:`RCR_PEAK_LSB];
   assign ch3_peak_current_code = (peak_raw > peak_code_cap) ?
                                  peak_code_cap : peak_raw;
   assign ch3_peak_code_valid =
      (ch3_peak_current_code >= `RCR_PEAK_MIN_CODE);

   assign ch3_ramp_code =
      ch3_config_reg[`RCR_RAMP_MSB:`RCR_RAMP_LSB];

   ////////////////////////////////////////////////////////////////////////////
   // Channel four field decode; bit 2 is reserved here
   assign ch4_residual_check_en = ch4_control_reg[`RCR_BIT_RESIDUAL];
   assign ch4_pulldown_en       = ch4_control_reg[`RCR_BIT_PULLDOWN];
   assign ch4_monitor_en        = ch4_control_reg[`RCR_BIT_MONITOR];
   assign ch4_setpoint_select   = ch4_control_reg[`RCR_BIT_SETPOINT];
   assign ch4_force_pwm         = ch4_control_reg[`RCR_BIT_FORCE_PWM];
   assign ch4_regulator_on      = ch4_control_reg[`RCR_BIT_REG_ON];
   assign ch4_pulldown_active   = ch4_pulldown_en & ~ch4_regulator_on;
   assign ch4_setpoint_active   = ch4_setpoint_select ? ch4_setpoint_b
                                                      : ch4_setpoint_a;
   assign ch4_pulse_frequency_allowed = ~ch4_force_pwm;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (1'b0);

   chk_reset_image: assert property (
      reset && !nvm_valid |=> ch3_control_reg == `RCR_RESET_IMAGE
                              && ch3_config_reg == `RCR_RESET_IMAGE
                              && ch4_control_reg == `RCR_RESET_IMAGE)
      else $error("printed reset image not loaded");

   chk_nvm_reserved_zero: assert property (
      reset |=> ch3_control_reg[6] == 1'b0 && ch3_config_reg[7:6] == 2'b00
                && ch4_control_reg[2] == 1'b0)
      else $error("reserved bit not zero after reset");

   chk_write_ctrl3: assert property (disable iff (reset)
      reg_wr_en && reg_addr == `RCR_OFS_CH3_CONTROL
      |=> ch3_control_reg == $past(reg_wr_data))
      else $error("channel three control write lost");

   chk_write_config: assert property (disable iff (reset)
      reg_wr_en && reg_addr == `RCR_OFS_CH3_CONFIG && ch3_regulator_on
      |=> ch3_config_reg == $past(reg_wr_data))
      else $error("config write refused while running");

   chk_read_back: assert property (disable iff (reset)
      reg_rd_en && reg_addr == `RCR_OFS_CH4_CONTROL && !reg_wr_en
      |=> reg_rd_valid && reg_rd_data == $past(ch4_control_reg))
      else $error("channel four control read mismatch");

   chk_pulldown_off: assert property (disable iff (reset)
      ch3_pulldown_active == (ch3_control_reg[5] && !ch3_control_reg[0]))
      else $error("pull-down not tied to disabled channel");

   chk_peak_cap: assert property (disable iff (reset)
      ch3_peak_current_code <= peak_code_cap
      && ch3_peak_current_code <= ch3_config_reg[5:3])
      else $error("applied peak code above cap or stored code");

   chk_all_phase_pwm: assert property (
      ch3_control_reg[2] |-> !ch3_pulse_frequency_allowed)
      else $error("all-phase mode allowed pulse frequency switching");

   chk_setpoint_mux: assert property (disable iff (reset)
      ch4_setpoint_active == (ch4_control_reg[3] ? ch4_setpoint_b
                                                 : ch4_setpoint_a))
      else $error("channel four setpoint mux wrong");

   chk_comparator_gate: assert property (disable iff (reset)
      ch3_overvoltage_cmp_en == ch3_control_reg[4]
      && ch3_undervoltage_cmp_en == ch3_control_reg[4]
      && ch3_short_circuit_cmp_en == ch3_control_reg[4]
      && ch3_current_limit_cmp_en == ch3_control_reg[4])
      else $error("comparator gate not following monitor bit");

   // Reserved bits of the stored image must come back masked to zero
   chk_nvm_image: assert property (
      reset && nvm_valid
      |=> ch3_control_reg == ($past(nvm_ch3_control) & 8'hBF)
          && ch3_config_reg == ($past(nvm_ch3_config) & 8'h3F)
          && ch4_control_reg == ($past(nvm_ch4_control) & 8'hBB))
      else $error("nonvolatile default image not loaded");

   chk_write_ctrl4: assert property (disable iff (reset)
      reg_wr_en && reg_addr == `RCR_OFS_CH4_CONTROL
      |=> ch4_control_reg == $past(reg_wr_data))
      else $error("channel four control write lost");

   chk_unmapped_read: assert property (disable iff (reset)
      reg_rd_en && reg_addr != `RCR_OFS_CH3_CONTROL
      && reg_addr != `RCR_OFS_CH3_CONFIG
      && reg_addr != `RCR_OFS_CH4_CONTROL
      |=> reg_rd_valid && reg_rd_data == 8'h00)
      else $error("unmapped offset did not read zero");

   chk_rd_valid_pulse: assert property (disable iff (reset)
      !reg_rd_en |=> !reg_rd_valid)
      else $error("read valid without a read strobe");

   chk_ramp_field: assert property (disable iff (reset)
      ch3_ramp_code == ch3_config_reg[2:0])
      else $error("ramp code not taken from config bits 2:0");

   chk_peak_valid: assert property (disable iff (reset)
      ch3_peak_code_valid == (ch3_peak_current_code > 3'h1))
      else $error("reserved peak code not flagged");

   chk_ch3_bits: assert property (disable iff (reset)
      ch3_residual_check_en == ch3_control_reg[7]
      && ch3_regulator_on == ch3_control_reg[0]
      && ch3_force_pwm == ch3_control_reg[1])
      else $error("channel three control bit not at its position");

   chk_ch4_outputs: assert property (disable iff (reset)
      ch4_pulldown_active == (ch4_control_reg[5] && !ch4_control_reg[0])
      && ch4_pulse_frequency_allowed == !ch4_control_reg[1])
      else $error("channel four pull-down or switching mode wrong");

   chk_ch3_setpoint: assert property (disable iff (reset)
      ch3_setpoint_active == (ch3_control_reg[3] ? ch3_setpoint_b
                                                 : ch3_setpoint_a))
      else $error("channel three setpoint mux wrong");

   cov_enable_ch3: cover property (
      !ch3_regulator_on ##1 ch3_regulator_on);
   cov_unmapped_read: cover property (
      reg_rd_en && reg_addr == 8'h0B);
   cov_peak_capped: cover property (
      ch3_config_reg[5:3] > peak_code_cap);
   cov_all_phase: cover property (
      ch3_force_all_phases && ch3_regulator_on);

endmodule

// ===== src/rcr_cfg.svh
// Offsets, field positions, reset images and decode constants for the block
`ifndef RCR_CFG_SVH
`define RCR_CFG_SVH

// Register offsets on the register port
`define RCR_OFS_CH3_CONTROL   8'h08
`define RCR_OFS_CH3_CONFIG    8'h09
`define RCR_OFS_CH4_CONTROL   8'h0A

// Printed reset image of every register
`define RCR_RESET_IMAGE       8'h22

// Control register bit positions
`define RCR_BIT_RESIDUAL      7
`define RCR_BIT_PULLDOWN      5
`define RCR_BIT_MONITOR       4
`define RCR_BIT_SETPOINT      3
`define RCR_BIT_ALL_PHASES    2
`define RCR_BIT_FORCE_PWM     1
`define RCR_BIT_REG_ON        0

// Masks on the nonvolatile image; reserved bits stay storable but reset to zero
`define RCR_CTRL_LIVE_MASK    8'hBF
`define RCR_CH4_LIVE_MASK     8'hBB
`define RCR_CONF_LIVE_MASK    8'h3F

// Configuration register fields
`define RCR_PEAK_MSB          5
`define RCR_PEAK_LSB          3
`define RCR_RAMP_MSB          2
`define RCR_RAMP_LSB          0

// Lowest peak current code that is not reserved (2.5 A)
`define RCR_PEAK_MIN_CODE     3'h2
// Highest peak current code (7.5 A)
`define RCR_PEAK_MAX_CODE     3'h7

// Read answer for an unmapped offset
`define RCR_UNMAPPED_DATA     8'h00

`endif

// ===== src/rcr_pkg.sv
// Types shared by the regulator control register bank
package rcr_pkg;

   typedef logic [7:0] rcr_byte_t;
   typedef logic [7:0] rcr_addr_t;
   typedef logic [2:0] rcr_code_t;

   // Peak current limit codes; 000 and 001 are reserved
   typedef enum logic [2:0] {
      RCR_PEAK_RSV0  = 3'h0,
      RCR_PEAK_RSV1  = 3'h1,
      RCR_PEAK_2A5   = 3'h2,
      RCR_PEAK_3A5   = 3'h3,
      RCR_PEAK_4A5   = 3'h4,
      RCR_PEAK_5A5   = 3'h5,
      RCR_PEAK_6A5   = 3'h6,
      RCR_PEAK_7A5   = 3'h7
   } rcr_peak_t;

   // Ramp codes, from fastest to slowest output slew
   typedef enum logic [2:0] {
      RCR_RAMP_33    = 3'h0,
      RCR_RAMP_20    = 3'h1,
      RCR_RAMP_10    = 3'h2,
      RCR_RAMP_5     = 3'h3,
      RCR_RAMP_2P5   = 3'h4,
      RCR_RAMP_1P3   = 3'h5,
      RCR_RAMP_0P63  = 3'h6,
      RCR_RAMP_0P31  = 3'h7
   } rcr_ramp_t;

endpackage

// ===== test/rcr_host.sv
// Host model that drives the register port of the regulator bank
`timescale 1ns/10ps

module rcr_host (
   input  wire logic               clk_sys,
   output rcr_pkg::rcr_addr_t      reg_addr,
   output logic                    reg_wr_en,
   output rcr_pkg::rcr_byte_t      reg_wr_data,
   output logic                    reg_rd_en,
   input  wire rcr_pkg::rcr_byte_t reg_rd_data,
   input  wire logic               reg_rd_valid
);
   import rcr_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Idle lines show the inverse of the last value, so stale data never
   // passes for a fresh transfer
   initial begin
      reg_addr    = 8'hFF;
      reg_wr_en   = 1'b0;
      reg_wr_data = 8'hFF;
      reg_rd_en   = 1'b0;
   end

   // One-cycle write strobe launched off the falling edge
   task automatic wr(input rcr_addr_t a, input rcr_byte_t d);
      @(negedge clk_sys);
      reg_addr    = a;
      reg_wr_data = d;
      reg_wr_en   = 1'b1;
      @(negedge clk_sys);
      reg_wr_en   = 1'b0;
      reg_addr    = ~a;
      reg_wr_data = ~d;
   endtask

   // Answer stands one cycle only, so it is taken on the next falling edge
   task automatic rd(input rcr_addr_t a, output rcr_byte_t d,
                     output logic ok);
      @(negedge clk_sys);
      reg_addr  = a;
      reg_rd_en = 1'b1;
      @(negedge clk_sys);
      reg_rd_en = 1'b0;
      reg_addr  = ~a;
      ok        = (reg_rd_valid === 1'b1);
      d         = reg_rd_data;
   endtask

endmodule

// ===== test/regulator_control_regs_tb.sv
// Self-checking bench for the regulator control register bank
`timescale 1ns/10ps

module regulator_control_regs_tb;
   import rcr_pkg::*;

   localparam rcr_byte_t SP3A = 8'h3C, SP3B = 8'hC3;
   localparam rcr_byte_t SP4A = 8'h5A, SP4B = 8'hA5;

   logic      clk_sys = 1'b0, reset = 1'b1, nvm_valid = 1'b0;
   logic      reg_wr_en, reg_rd_en, reg_rd_valid;
   rcr_addr_t reg_addr;
   rcr_byte_t reg_wr_data, reg_rd_data;
   rcr_byte_t nvm_ch3_control = 8'h00, nvm_ch3_config = 8'h00;
   rcr_byte_t nvm_ch4_control = 8'h00;
   rcr_code_t peak_code_cap = 3'h7, ch3_peak_current_code, ch3_ramp_code;
   rcr_byte_t ch3_setpoint_a = SP3A, ch3_setpoint_b = SP3B;
   rcr_byte_t ch4_setpoint_a = SP4A, ch4_setpoint_b = SP4B;
   rcr_byte_t ch3_setpoint_active, ch4_setpoint_active;
   logic ch3_residual_check_en, ch3_pulldown_en, ch3_monitor_en;
   logic ch3_setpoint_select, ch3_force_all_phases, ch3_force_pwm;
   logic ch3_regulator_on, ch3_peak_code_valid, ch3_pulldown_active;
   logic ch3_overvoltage_cmp_en, ch3_undervoltage_cmp_en;
   logic ch3_short_circuit_cmp_en, ch3_current_limit_cmp_en;
   logic ch3_pulse_frequency_allowed, ch4_residual_check_en;
   logic ch4_pulldown_en, ch4_monitor_en, ch4_setpoint_select;
   logic ch4_force_pwm, ch4_regulator_on, ch4_pulldown_active;
   logic ch4_pulse_frequency_allowed;
   int   fail_count = 0, tests_run = 0;

   rcr_host u_host (.clk_sys, .reg_addr, .reg_wr_en, .reg_wr_data,
      .reg_rd_en, .reg_rd_data, .reg_rd_valid);

   rcr_regs u_dut (.clk_sys, .reset, .reg_addr, .reg_wr_en, .reg_wr_data,
      .reg_rd_en, .reg_rd_data, .reg_rd_valid, .nvm_valid, .nvm_ch3_control,
      .nvm_ch3_config, .nvm_ch4_control, .peak_code_cap, .ch3_setpoint_a,
      .ch3_setpoint_b, .ch4_setpoint_a, .ch4_setpoint_b,
      .ch3_residual_check_en, .ch3_pulldown_en, .ch3_monitor_en,
      .ch3_setpoint_select, .ch3_force_all_phases, .ch3_force_pwm,
      .ch3_regulator_on, .ch3_peak_current_code, .ch3_peak_code_valid,
      .ch3_ramp_code, .ch3_setpoint_active, .ch3_pulldown_active,
      .ch3_overvoltage_cmp_en, .ch3_undervoltage_cmp_en,
      .ch3_short_circuit_cmp_en, .ch3_current_limit_cmp_en,
      .ch3_pulse_frequency_allowed, .ch4_residual_check_en,
      .ch4_pulldown_en, .ch4_monitor_en, .ch4_setpoint_select,
      .ch4_force_pwm, .ch4_regulator_on, .ch4_setpoint_active,
      .ch4_pulldown_active, .ch4_pulse_frequency_allowed);

   // 100 MHz system clock
   always #5 clk_sys = ~clk_sys;

   ////////////////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic check_byte(input rcr_byte_t got, input rcr_byte_t exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input rcr_addr_t a, input rcr_byte_t exp);
      rcr_byte_t d;
      logic      ok;
      u_host.rd(a, d, ok);
      check_byte({7'h00, ok}, 8'h01);
      check_byte(d, exp);
   endtask

   // Reset held for 10 cycles; defaults picked by nvm_valid
   task automatic do_reset(input logic use_nvm);
      @(negedge clk_sys);
      nvm_valid = use_nvm;
      reset     = 1'b1;
      repeat (10) @(negedge clk_sys);
      reset = 1'b0;
   endtask

   task automatic check_ch3(input rcr_byte_t w);
      check_byte({ch3_residual_check_en, 1'b0, ch3_pulldown_en,
         ch3_monitor_en, ch3_setpoint_select, ch3_force_all_phases,
         ch3_force_pwm, ch3_regulator_on}, w & 8'hBF);
      check_byte({2'h0, ch3_pulldown_active, ch3_overvoltage_cmp_en,
         ch3_undervoltage_cmp_en, ch3_short_circuit_cmp_en,
         ch3_current_limit_cmp_en, ch3_pulse_frequency_allowed},
         {2'h0, w[5] & ~w[0], {4{w[4]}}, ~(w[1] | w[2])});
      check_byte(ch3_setpoint_active, w[3] ? SP3B : SP3A);
   endtask

   task automatic check_ch4(input rcr_byte_t w);
      check_byte({ch4_residual_check_en, 1'b0, ch4_pulldown_en,
         ch4_monitor_en, ch4_setpoint_select, 1'b0, ch4_force_pwm,
         ch4_regulator_on}, w & 8'hBB);
      check_byte({6'h00, ch4_pulldown_active, ch4_pulse_frequency_allowed},
         {6'h00, w[5] & ~w[0], ~w[1]});
      check_byte(ch4_setpoint_active, w[3] ? SP4B : SP4A);
   endtask

   // Applied limit is the stored code capped; codes below 2 are reserved
   task automatic check_cfg(input rcr_byte_t c);
      rcr_code_t p;
      p = (c[5:3] > peak_code_cap) ? peak_code_cap : c[5:3];
      check_byte({ch3_peak_code_valid, ch3_peak_current_code, 1'b0,
         ch3_ramp_code}, {p >= 3'h2, p, 1'b0, c[2:0]});
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic test_reset_image();
      do_reset(1'b0);
      rd_chk(8'h08, 8'h22);
      rd_chk(8'h09, 8'h22);
      rd_chk(8'h0A, 8'h22);
      check_ch3(8'h22);
      check_ch4(8'h22);
      check_cfg(8'h22);
      $display("test_reset_image done");
   endtask

   // Distinct images prove each register loads its own default
   task automatic test_nvm_load();
      nvm_ch3_control = 8'hD9;
      nvm_ch3_config  = 8'hFD;
      nvm_ch4_control = 8'h77;
      do_reset(1'b1);
      rd_chk(8'h08, 8'h99);
      rd_chk(8'h09, 8'h3D);
      rd_chk(8'h0A, 8'h33);
      check_ch3(8'h99);
      check_ch4(8'h33);
      check_cfg(8'h3D);
      $display("test_nvm_load done");
   endtask

   // Walking one per bit, then all set and all clear
   task automatic test_control();
      rcr_byte_t v;
      for (int i = 0; i < 10; i++) begin
         v = (i < 8) ? (8'h01 << i) : ((i == 8) ? 8'hFF : 8'h00);
         u_host.wr(8'h08, v);
         check_ch3(v);
         u_host.wr(8'h0A, ~v);
         check_ch4(~v);
         rd_chk(8'h08, v);
         rd_chk(8'h0A, ~v);
      end
      $display("test_control done");
   endtask

   // Every limit and ramp code, reserved bits kept set
   task automatic test_config();
      rcr_byte_t v;
      for (int i = 0; i < 64; i++) begin
         v = 8'(i) ^ 8'hC0;
         u_host.wr(8'h09, v);
         check_cfg(v);
         rd_chk(8'h09, v);
      end
      $display("test_config done");
   endtask

   // Limit rewritten with the regulator running, under every cap
   task automatic test_cap_running();
      rcr_byte_t v;
      u_host.wr(8'h08, 8'h01);
      for (int c = 0; c < 8; c++) begin
         v = c[0] ? 8'h3A : 8'h1B;
         peak_code_cap = 3'(c);
         u_host.wr(8'h09, v);
         check_cfg(v);
         rd_chk(8'h09, v);
      end
      peak_code_cap = 3'h7;
      $display("test_cap_running done");
   endtask

   // Writes beside the map change nothing and read as zero
   task automatic test_unmapped();
      u_host.wr(8'h08, 8'h21);
      u_host.wr(8'h09, 8'h13);
      u_host.wr(8'h0A, 8'h18);
      u_host.wr(8'h0B, 8'h55);
      u_host.wr(8'h07, 8'hAA);
      rd_chk(8'h0B, 8'h00);
      rd_chk(8'h07, 8'h00);
      rd_chk(8'h08, 8'h21);
      rd_chk(8'h09, 8'h13);
      rd_chk(8'h0A, 8'h18);
      $display("test_unmapped done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Verdict, main sequence and watchdog
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      test_reset_image();
      test_nvm_load();
      test_control();
      test_config();
      test_cap_running();
      test_unmapped();
      give_verdict();
   end

   // Run needs well under 2000 cycles; 20000 means a hang
   initial begin
      #200000;
      fail_count++;
      give_verdict();
   end

endmodule
